// ### hdl/mii_gpio_pin_mux.sv
// How it works
// RULE1 - Channel-1 pins carry the interface function when its select is interface mode, else port bits.
// RULE2 - Channel-2 pins follow their own select in the same way.
// RULE3 - Channel-1 receive data 1 to 3, receive error, mgmt clock and mgmt data are port bits 12 to 17.
// RULE4 - The eighteen channel-2 pins are port bits 18 to 35 in pin order.
// RULE5 - In interface mode the mgmt clock pin is driven as an output.
// RULE6 - In interface mode the mgmt data pin is two-way, driven by whichever side owns the phase.
// RULE7 - The PHY supplies the transmit clock on an input pin.
// RULE8 - In interface mode transmit enable is driven as an output.
// RULE9 - In interface mode the four transmit data lines are driven as outputs.
// RULE10 - In interface mode transmit error is driven as an output.
// RULE11 - Collision and carrier sense are inputs, held low by the outside on an unused channel.
// RULE12 - Receive error is an input, held low by the outside on an unused channel.
// RULE13 - Receive data valid is an input, held at a constant level on an unused channel.
// RULE14 - The PHY supplies the receive clock on an input pin.
// RULE15 - The PHY delivers receive data on four input lines.
// RULE16 - Channel-1 transmit clock through receive data 0 are port bits 0 to 11.
// RULE17 - In port mode the MAC sees inactive inputs and its outputs do not reach the pins.
`timescale 1ns/1ns
`default_nettype none
`include "mii_gpio_pin_mux_consts.svh"

module mii_gpio_pin_mux
  import mii_gpio_pin_mux_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     chan1_pin_function_select,
  input  wire logic                     chan2_pin_function_select,
  input  wire logic [`ALL_PINS-1:0]     pinIn,
  output logic      [`ALL_PINS-1:0]     pinOut_q,
  output logic      [`ALL_PINS-1:0]     pinOe_q,
  input  wire logic [`ALL_PINS-1:0]     gpOut,
  input  wire logic [`ALL_PINS-1:0]     gpOe,
  output logic      [`ALL_PINS-1:0]     gpIn_q,
  input  wire logic [`CHANNELS-1:0]     macTxEn,
  input  wire logic [4*`CHANNELS-1:0]   macTxData,
  input  wire logic [`CHANNELS-1:0]     macTxErr,
  input  wire logic [`CHANNELS-1:0]     macMgmtClock,
  input  wire logic [`CHANNELS-1:0]     macMgmtDataOut,
  input  wire logic [`CHANNELS-1:0]     macMgmtDataOe,
  output logic      [`CHANNELS-1:0]     macTxClock_q,
  output logic      [`CHANNELS-1:0]     macTxClockRise_q,
  output logic      [`CHANNELS-1:0]     macRxClock_q,
  output logic      [`CHANNELS-1:0]     macRxClockRise_q,
  output logic      [`CHANNELS-1:0]     macCollision_q,
  output logic      [`CHANNELS-1:0]     macCarrierSense_q,
  output logic      [`CHANNELS-1:0]     macRxValid_q,
  output logic      [4*`CHANNELS-1:0]   macRxData_q,
  output logic      [`CHANNELS-1:0]     macRxErr_q,
  output logic      [`CHANNELS-1:0]     macMgmtDataIn_q
);

  logic [`CHANNELS-1:0] miiMode;
  logic [`ALL_PINS-1:0] syncPins;
  logic [`ALL_PINS-1:0] pinOut_d;
  logic [`ALL_PINS-1:0] pinOe_d;
  logic [`CHANNELS-1:0] txClockPrev_q;
  logic [`CHANNELS-1:0] rxClockPrev_q;
  logic [2:0]           validCount_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // The selects come from logic on this clock and need no synchroniser.
  assign miiMode = {chan2_pin_function_select, chan1_pin_function_select};

  // Every pin level enters through two flip-flops before any logic looks at it.
  pin_sync
  #(
    .WIDTH (`ALL_PINS)
  )
  u_pin_sync
  (
    .clk       (clk),
    .reset     (reset),
    .asyncIn   (pinIn),
    .syncOut_q (syncPins)
  );

  // Output levels of one channel's pins in interface mode.
  function automatic chan_pins_t miiDrive(input logic en, input logic [3:0] data,
                                          input logic err, input logic mdc,
                                          input logic mdo);
    chan_pins_t v;
    v = '0;
    v[`PIN_TX_EN]       = en;
    v[`PIN_TX_D +: 4]   = data;
    v[`PIN_TX_ER]       = err;
    v[`PIN_MDC]         = mdc;
    v[`PIN_MD]          = mdo;
    return v;
  endfunction : miiDrive

  // Output enables of one channel's pins in interface mode.
  function automatic chan_pins_t miiEnable(input logic mdOe);
    chan_pins_t v;
    v = `MII_OE_FIXED;
    v[`PIN_MD] = mdOe;
    return v;
  endfunction : miiEnable

  always_comb
  begin
    pinOut_d = `PINS_RST;
    pinOe_d  = `PINS_RST;
    for (int c = 0; c < `CHANNELS; c++)
    begin
      if (miiMode[c] == MODE_MII)
      begin
        // RULE1 RULE2 RULE5 RULE6 RULE8 RULE9 RULE10
        pinOut_d[c*`CH_PINS +: `CH_PINS] = miiDrive(macTxEn[c], macTxData[4*c +: 4],
                                                    macTxErr[c], macMgmtClock[c],
                                                    macMgmtDataOut[c]);
        pinOe_d[c*`CH_PINS +: `CH_PINS]  = miiEnable(macMgmtDataOe[c]);
      end
      else
      begin
        // RULE3 RULE4 RULE16 RULE17
        pinOut_d[c*`CH_PINS +: `CH_PINS] = gpOut[c*`CH_PINS +: `CH_PINS];
        pinOe_d[c*`CH_PINS +: `CH_PINS]  = gpOe[c*`CH_PINS +: `CH_PINS];
      end
    end
  end

  // Pins start released so that nothing fights the board at power-up.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pinOut_q <= `PINS_RST;
      pinOe_q  <= `PINS_RST;
    end
    else
    begin
      pinOut_q <= pinOut_d;
      pinOe_q  <= pinOe_d;
    end
  end

  // The port reads back every pin level whatever the mode.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gpIn_q <= `PINS_RST;
    end
    else
    begin
      gpIn_q <= syncPins; // RULE3 RULE4 RULE16
    end
  end

  // Levels from the PHY reach the MAC only in interface mode.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      macTxClock_q      <= '0;
      macRxClock_q      <= '0;
      macCollision_q    <= '0;
      macCarrierSense_q <= '0;
      macRxValid_q      <= '0;
      macRxData_q       <= '0;
      macRxErr_q        <= '0;
      macMgmtDataIn_q   <= '0;
    end
    else
    begin
      for (int c = 0; c < `CHANNELS; c++)
      begin
        if (miiMode[c] == MODE_MII)
        begin
          macTxClock_q[c]        <= syncPins[c*`CH_PINS + `PIN_TX_CLK]; // RULE7
          macRxClock_q[c]        <= syncPins[c*`CH_PINS + `PIN_RX_CLK]; // RULE14
          macCollision_q[c]      <= syncPins[c*`CH_PINS + `PIN_COL]; // RULE11
          macCarrierSense_q[c]   <= syncPins[c*`CH_PINS + `PIN_CRS]; // RULE11
          macRxValid_q[c]        <= syncPins[c*`CH_PINS + `PIN_RX_DV]; // RULE13
          macRxData_q[4*c +: 4]  <= syncPins[c*`CH_PINS + `PIN_RX_D +: 4]; // RULE15
          macRxErr_q[c]          <= syncPins[c*`CH_PINS + `PIN_RX_ER]; // RULE12
          macMgmtDataIn_q[c]     <= syncPins[c*`CH_PINS + `PIN_MD]; // RULE6
        end
        else
        begin
          macTxClock_q[c]        <= 1'b0; // RULE17
          macRxClock_q[c]        <= 1'b0;
          macCollision_q[c]      <= 1'b0;
          macCarrierSense_q[c]   <= 1'b0;
          macRxValid_q[c]        <= 1'b0;
          macRxData_q[4*c +: 4]  <= 4'h0;
          macRxErr_q[c]          <= 1'b0;
          macMgmtDataIn_q[c]     <= 1'b0;
        end
      end
    end
  end

  // Rising edges of the PHY clocks become one-cycle pulses for the MAC.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      txClockPrev_q    <= '0;
      rxClockPrev_q    <= '0;
      macTxClockRise_q <= '0;
      macRxClockRise_q <= '0;
    end
    else
    begin
      for (int c = 0; c < `CHANNELS; c++)
      begin
        txClockPrev_q[c]    <= syncPins[c*`CH_PINS + `PIN_TX_CLK];
        rxClockPrev_q[c]    <= syncPins[c*`CH_PINS + `PIN_RX_CLK];
        macTxClockRise_q[c] <= miiMode[c] & syncPins[c*`CH_PINS + `PIN_TX_CLK]
                               & ~txClockPrev_q[c]; // RULE7
        macRxClockRise_q[c] <= miiMode[c] & syncPins[c*`CH_PINS + `PIN_RX_CLK]
                               & ~rxClockPrev_q[c]; // RULE14
      end
    end
  end

  // Counts cycles since reset so that the checks see a filled pipeline.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      validCount_q <= 3'h0;
    end
    else if (validCount_q != `VALID_FULL)
    begin
      validCount_q <= validCount_q + 3'h1;
    end
  end

  sequence txClockRose;
    (validCount_q == `VALID_FULL) && $rose(pinIn[`PIN_TX_CLK]) && miiMode[0];
  endsequence

  sequence chan1Held;
    miiMode[0] [*2];
  endsequence

  chan1_route_a: assert property ( // RULE1
    (validCount_q != 3'h0) && !$past(miiMode[0])
      |-> pinOut_q[17:0] == $past(gpOut[17:0]) && pinOe_q[17:0] == $past(gpOe[17:0]))
    else $error("Channel 1 pins do not follow the port bits.");

  chan2_route_a: assert property ( // RULE2
    (validCount_q != 3'h0) && $past(miiMode[1])
      |-> pinOe_q[35:18] == {$past(macMgmtDataOe[1]), 17'(`MII_OE_FIXED)})
    else $error("Channel 2 pin directions wrong in interface mode.");

  gp_high_map_a: assert property ( // RULE3
    (validCount_q >= 3'h3) |-> gpIn_q[17:12] == $past(pinIn[17:12], 3))
    else $error("Port bits 12 to 17 do not read the channel 1 pins.");

  gp_chan2_map_a: assert property ( // RULE4
    (validCount_q >= 3'h3) |-> gpIn_q[35:18] == $past(pinIn[35:18], 3))
    else $error("Port bits 18 to 35 do not read the channel 2 pins.");

  mgmt_clock_drive_a: assert property ( // RULE5
    (validCount_q != 3'h0) && $past(miiMode[0])
      |-> pinOe_q[16] && pinOut_q[16] == $past(macMgmtClock[0]))
    else $error("Management clock pin not driven from the MAC.");

  mgmt_data_dir_a: assert property ( // RULE6
    (validCount_q != 3'h0) && $past(miiMode[1])
      |-> pinOe_q[35] == $past(macMgmtDataOe[1]) && pinOut_q[35] == $past(macMgmtDataOut[1]))
    else $error("Management data pin direction does not follow the MAC.");

  tx_clock_edge_a: assert property ( // RULE7
    txClockRose ##1 chan1Held |-> ##1 macTxClockRise_q[0])
    else $error("Transmit clock edge not reported to the MAC.");

  tx_enable_route_a: assert property ( // RULE8
    (validCount_q != 3'h0) && $past(miiMode[0])
      |-> pinOe_q[1] && pinOut_q[1] == $past(macTxEn[0]))
    else $error("Transmit enable pin not driven from the MAC.");

  tx_data_route_a: assert property ( // RULE9
    (validCount_q != 3'h0) && $past(miiMode[1])
      |-> pinOe_q[23:20] == 4'hF && pinOut_q[23:20] == $past(macTxData[7:4]))
    else $error("Transmit data pins not driven from the MAC.");

  tx_error_route_a: assert property ( // RULE10
    (validCount_q != 3'h0) && $past(miiMode[0])
      |-> pinOe_q[6] && pinOut_q[6] == $past(macTxErr[0]))
    else $error("Transmit error pin not driven from the MAC.");

  low_map_a: assert property ( // RULE16
    (validCount_q >= 3'h3) |-> gpIn_q[11:0] == $past(pinIn[11:0], 3))
    else $error("Port bits 0 to 11 do not read the channel 1 pins.");

  gp_inactive_a: assert property ( // RULE17
    (validCount_q != 3'h0) && !$past(miiMode[0])
      |-> !macRxValid_q[0] && !macCollision_q[0] && !macCarrierSense_q[0]
          && macRxData_q[3:0] == 4'h0 && !macRxErr_q[0] && !macTxClockRise_q[0])
    else $error("MAC inputs not quiet while channel 1 is a port.");

endmodule : mii_gpio_pin_mux

`default_nettype wire

// ### hdl/mii_gpio_pin_mux_consts.svh
`ifndef MII_GPIO_PIN_MUX_CONSTS_SVH
`define MII_GPIO_PIN_MUX_CONSTS_SVH

// Number of channels and shared pins per channel.
`define CHANNELS      2
`define CH_PINS       18
`define ALL_PINS      36

// Pin position of each function inside one channel's group of pins.
`define PIN_TX_CLK    0
`define PIN_TX_EN     1
`define PIN_TX_D      2
`define PIN_TX_ER     6
`define PIN_COL       7
`define PIN_CRS       8
`define PIN_RX_CLK    9
`define PIN_RX_DV     10
`define PIN_RX_D      11
`define PIN_RX_ER     15
`define PIN_MDC       16
`define PIN_MD        17

// Pins that are always driven in interface mode: transmit enable, data, error, mgmt clock.
`define MII_OE_FIXED  18'h1007E

// Reset values and the warm-up count used by the checks.
`define PINS_RST      36'h0
`define VALID_FULL    3'h4

`endif

// ### hdl/mii_gpio_pin_mux_pkg.sv
`default_nettype none

package mii_gpio_pin_mux_pkg;

  typedef enum logic
  {
    MODE_GP  = 1'b0,
    MODE_MII = 1'b1
  } pin_mode_e;

  typedef logic [17:0] chan_pins_t;

endpackage : mii_gpio_pin_mux_pkg

`default_nettype wire

// ### hdl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync
#(
  parameter int WIDTH = 36
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut_q
);

  logic [WIDTH-1:0] stage1_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage1_q  <= '0;
      syncOut_q <= '0;
    end
    else
    begin
      stage1_q  <= asyncIn;
      syncOut_q <= stage1_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ### sim/mii_gpio_pin_mux_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mii_gpio_pin_mux_consts.svh"

module mii_gpio_pin_mux_bench;
  localparam logic [35:0] GP_LVL = 36'h9A5C396F0;
  localparam logic [35:0] GP_EN  = 36'hC3F0A5F0F;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        chan1_pin_function_select, chan2_pin_function_select;
  logic [1:0]  macTxEn, macTxErr, macMgmtClock, macMgmtDataOut, macMgmtDataOe;
  logic [1:0]  phyAttach, phyRun, phyDv, phyEr, phyCol, phyCrs, phyMdEn, phyMdVal;
  logic [7:0]  macTxData, phyRxd, macRxData_q;
  logic [35:0] gpOut, gpOe, pinIn, pinOut_q, pinOe_q, gpIn_q;
  wire  logic [35:0] phyLevel, phyDrive;
  logic [1:0]  macTxClock_q, macTxClockRise_q, macRxClock_q, macRxClockRise_q;
  logic [1:0]  macCollision_q, macCarrierSense_q, macRxValid_q, macRxErr_q, macMgmtDataIn_q;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;

  mii_gpio_pin_mux u_mii_gpio_pin_mux
  (
    .clk, .reset, .chan1_pin_function_select, .chan2_pin_function_select,
    .pinIn, .pinOut_q, .pinOe_q, .gpOut, .gpOe, .gpIn_q, .macTxEn, .macTxData, .macTxErr,
    .macMgmtClock, .macMgmtDataOut, .macMgmtDataOe, .macTxClock_q, .macTxClockRise_q,
    .macRxClock_q, .macRxClockRise_q, .macCollision_q, .macCarrierSense_q, .macRxValid_q,
    .macRxData_q, .macRxErr_q, .macMgmtDataIn_q
  );

  for (genvar c = 0; c < 2; c++)
  begin : chan
    mii_phy_model u_mii_phy_model
    (
      .attach   (phyAttach[c]),
      .run      (phyRun[c]),
      .rxNibble (phyRxd[4*c+:4]),
      .rxValid  (phyDv[c]),
      .rxErr    (phyEr[c]),
      .col      (phyCol[c]),
      .crs      (phyCrs[c]),
      .mdDrive  (phyMdEn[c]),
      .mdLevel  (phyMdVal[c]),
      .level    (phyLevel[18*c+:18]),
      .drive    (phyDrive[18*c+:18])
    );
  end

  // Each pin has a weak pull-down, so a pin nobody drives reads low.
  assign pinIn = (pinOe_q & pinOut_q) | (~pinOe_q & phyDrive & phyLevel);

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic t_gp;
    @(posedge clk);
    {chan2_pin_function_select, chan1_pin_function_select} <= 2'b00;
    phyAttach <= 2'b00;
    gpOut <= GP_LVL;
    gpOe <= GP_EN;
    {macTxEn, macTxErr, macMgmtClock, macMgmtDataOut, macMgmtDataOe} <= 10'h3FF;
    macTxData <= 8'hFF;
    step(5);
    check("port enables", pinOe_q, GP_EN);
    check("port levels", pinOut_q & GP_EN, GP_LVL & GP_EN);
    check("port reads", gpIn_q, GP_LVL & GP_EN);
    check("mac inputs", {macRxData_q, macTxClock_q, macRxClock_q, macCollision_q,
      macCarrierSense_q, macRxValid_q, macRxErr_q, macMgmtDataIn_q, macTxClockRise_q,
      macRxClockRise_q}, 36'h0);
    $display("test port mode done");
  endtask : t_gp

  task automatic t_mii(input logic [1:0] mode);
    logic [35:0] expOe;
    logic [35:0] expLvl;
    @(posedge clk);
    {chan2_pin_function_select, chan1_pin_function_select} <= mode;
    phyAttach <= mode;
    phyMdEn <= 2'b10;
    macTxEn <= 2'b01;
    macTxData <= 8'h5A;
    macTxErr <= 2'b10;
    macMgmtClock <= 2'b01;
    macMgmtDataOut <= 2'b11;
    macMgmtDataOe <= 2'b01;
    step(3);
    expOe = {mode[1] ? `MII_OE_FIXED : GP_EN[35:18],
             mode[0] ? (`MII_OE_FIXED | 18'h20000) : GP_EN[17:0]};
    expLvl = {mode[1] ? 18'h00054 : GP_LVL[35:18], mode[0] ? 18'h3002A : GP_LVL[17:0]} & expOe;
    check("pin enables", pinOe_q, expOe);
    check("pin levels", pinOut_q & expOe, expLvl);
    $display("test interface mode %b done", mode);
  endtask : t_mii

  task automatic t_rx;
    int   linkRise;
    int   txSeen;
    int   rxSeen;
    logic prevLink;
    int   linkHigh;
    int   txHigh;
    int   rxHigh;
    int   tx2Seen;
    int   rx1Seen;
    linkRise = 0;
    txSeen = 0;
    rxSeen = 0;
    linkHigh = 0;
    txHigh = 0;
    rxHigh = 0;
    tx2Seen = 0;
    rx1Seen = 0;
    prevLink = 1'b0;
    @(posedge clk);
    {chan2_pin_function_select, chan1_pin_function_select} <= 2'b11;
    phyAttach <= 2'b11;
    macMgmtDataOe <= 2'b00;
    phyMdEn <= 2'b11;
    phyMdVal <= 2'b10;
    phyRxd <= 8'h1B;
    phyDv <= 2'b01;
    phyEr <= 2'b10;
    phyCol <= 2'b01;
    phyCrs <= 2'b10;
    step(5);
    check("rx data", macRxData_q, 8'h1B);
    check("rx flags", {macRxValid_q, macRxErr_q, macCollision_q, macCarrierSense_q},
      8'b01_10_01_10);
    check("mgmt data in", {macMgmtDataIn_q, pinOe_q[35], pinOe_q[17]}, 4'b1000);
    for (int i = 0; i < 260; i++)
    begin
      @(posedge clk);
      phyRun <= (i < 240) ? 2'b11 : 2'b00;
      #1;
      linkRise += int'(phyLevel[0] && !prevLink);
      prevLink = phyLevel[0];
      txSeen += int'(macTxClockRise_q[0]);
      rxSeen += int'(macRxClockRise_q[1]);
      tx2Seen += int'(macTxClockRise_q[1]);
      rx1Seen += int'(macRxClockRise_q[0]);
      linkHigh += int'(phyLevel[0]);
      txHigh += int'(macTxClock_q[0]);
      rxHigh += int'(macRxClock_q[1]);
    end
    check("link clock ran", 36'(linkRise > 10), 36'h1);
    check("tx clock edges", 36'(txSeen), 36'(linkRise));
    check("rx clock edges", 36'(rxSeen), 36'(linkRise));
    check("ch2 tx clock edges", 36'(tx2Seen), 36'(linkRise));
    check("ch1 rx clock edges", 36'(rx1Seen), 36'(linkRise));
    check("tx clock level", 36'(txHigh), 36'(linkHigh));
    check("rx clock level", 36'(rxHigh), 36'(linkHigh));
    $display("test receive path done");
  endtask : t_rx

  initial
  begin
    {chan1_pin_function_select, chan2_pin_function_select} = 2'b00;
    {macTxEn, macTxErr, macMgmtClock, macMgmtDataOut, macMgmtDataOe, macTxData} = 18'h0;
    {phyAttach, phyRun, phyDv, phyEr, phyCol, phyCrs, phyMdEn, phyMdVal, phyRxd} = 24'h0;
    gpOut = 36'h0;
    gpOe = 36'h0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("pins after reset", pinOe_q, 36'h0);
    t_gp();
    t_mii(2'b11);
    t_mii(2'b01);
    t_mii(2'b10);
    t_rx();
    tally_and_finish();
  end
endmodule : mii_gpio_pin_mux_bench

`default_nettype wire

// ### sim/mii_phy_model.sv
`timescale 1ns/1ns
`default_nettype none

module mii_phy_model
(
  input  wire logic        attach,
  input  wire logic        run,
  input  wire logic [3:0]  rxNibble,
  input  wire logic        rxValid,
  input  wire logic        rxErr,
  input  wire logic        col,
  input  wire logic        crs,
  input  wire logic        mdDrive,
  input  wire logic        mdLevel,
  output logic      [17:0] level,
  output logic      [17:0] drive
);
  logic linkClock = 1'b0;

  // The link clock stands low between bursts and toggles every 80 ns while run is high.
  always
  begin
    #80;
    linkClock = run ? ~linkClock : 1'b0;
  end

  // One clock feeds both the transmit and receive clock pins.
  assign level = {mdLevel, 1'b0, rxErr, rxNibble, rxValid, linkClock, crs, col, 6'h00,
                  linkClock};
  // The management data pin is only driven in the phase that the PHY owns.
  assign drive = attach ? {mdDrive, 1'b0, 9'h1FF, 6'h00, 1'b1}
                        : 18'h00000;
endmodule : mii_phy_model

`default_nettype wire
